/* rtl/cafr_pkg.sv */
`default_nettype none
package cafr_pkg;

	localparam logic [7:0] ADDR_TAG_BYTE_ONE = 8'hbc;
	localparam logic [7:0] ADDR_TAG_BYTE_TWO = 8'hbd;
	localparam logic [7:0] ADDR_TAG_BYTE_THREE = 8'hbe;
	localparam logic [7:0] ADDR_EXT_ID_TAG_LOW_BYTE = 8'hbf;
	localparam logic [7:0] ADDR_ID_MASK_BYTE_ONE = 8'hc4;
	localparam logic [7:0] ADDR_ID_MASK_BYTE_TWO = 8'hc5;
	localparam logic [7:0] ADDR_ID_MASK_BYTE_THREE = 8'hc6;
	localparam logic [7:0] ADDR_ID_MASK_BYTE_FOUR = 8'hc7;

	// Fourth byte field positions; POS_STD_LOW is a position in the second byte
	localparam int POS_ID_LOW = 3;
	localparam int POS_REMOTE = 2;
	localparam int POS_RES_ONE = 1;
	localparam int POS_RES_ZERO = 0;
	localparam int POS_EXT_FLAG = 0;
	localparam int POS_STD_LOW = 5;

	localparam int STD_ID_W = 11;
	localparam int EXT_ID_W = 29;

	// Reserved mask positions have no defined read value; zero is what this build returns
	localparam logic [7:0] RESERVED_READ = 8'h00;

	typedef enum logic [2:0]
	{
		CAFR_IDLE = 3'b001,
		CAFR_CMP = 3'b010,
		CAFR_DONE = 3'b100
	} cafr_state_e;

endpackage : cafr_pkg
`default_nettype wire

/* rtl/cafr_filt_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface cafr_filt_if;
	import cafr_pkg::*;
	logic [EXT_ID_W-1:0] tag_id;
	logic [EXT_ID_W-1:0] mask_id;
	logic tag_remote;
	logic mask_remote;
	logic mask_ext;
	logic tag_ext;
	logic [EXT_ID_W-1:0] rx_id;
	logic rx_remote;
	logic rx_ext;
	logic hit;

	modport ctrl
	(
		output tag_id, mask_id, tag_remote, mask_remote, mask_ext, tag_ext,
		output rx_id, rx_remote, rx_ext,
		input hit
	);
	modport cmp
	(
		input tag_id, mask_id, tag_remote, mask_remote, mask_ext, tag_ext,
		input rx_id, rx_remote, rx_ext,
		output hit
	);
endinterface : cafr_filt_if
`default_nettype wire

/* rtl/cafr_compare.sv */
`timescale 1ns/10ps
`default_nettype none
module cafr_compare
	import cafr_pkg::*;
#(
	parameter int ID_W = EXT_ID_W
)
(
	cafr_filt_if.cmp f
);
	logic [ID_W-1:0] bit_ok;

	// A cleared mask bit forces that bit to match
	genvar g;
	generate
		for (g = 0; g < ID_W; g++)
		begin : g_bit
			assign bit_ok[g] = ~f.mask_id[g] | (f.rx_id[g] == f.tag_id[g]);
		end
	endgenerate

	logic remote_ok;
	logic ext_ok;
	assign remote_ok = ~f.mask_remote | (f.rx_remote == f.tag_remote);
	assign ext_ok = ~f.mask_ext | (f.rx_ext == f.tag_ext);
	assign f.hit = (&bit_ok) & remote_ok & ext_ok;
endmodule // cafr_compare
`default_nettype wire

/* rtl/cafr_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module cafr_regs
	import cafr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Special-function-register access
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_hit_o,
	// Extended (29-bit) format select, else 11-bit
	input wire logic ext_format_i,
	// Reception candidate from the bit engine
	input wire logic rx_check_i,
	input wire logic rx_transmit_i,
	input wire logic [28:0] rx_id_i,
	input wire logic rx_remote_i,
	input wire logic rx_ext_i,
	input wire logic rx_res_one_i,
	input wire logic rx_res_zero_i,
	output logic rx_done_o,
	output logic rx_accept_o
);
	// Release is synchronised; assertion stays asynchronous
	logic rst_q1;
	logic rst_q2;
	logic rst_n;
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_q1 <= 1'b0;
			rst_q2 <= 1'b0;
		end
		else
		begin
			rst_q1 <= 1'b1;
			rst_q2 <= rst_q1;
		end
	end
	assign rst_n = rst_q2;

	// Storage has no reset: contents are undefined until software writes
	logic [7:0] tag1;
	logic [7:0] tag2;
	logic [7:0] tag3;
	logic [7:0] tag4;
	logic [7:0] msk1;
	logic [7:0] msk2;
	logic [7:0] msk3;
	logic [7:0] msk4;

	// One write select per byte; an unmapped address selects nothing
	logic wr_tag1;
	logic wr_tag2;
	logic wr_tag3;
	logic wr_tag4;
	logic wr_msk1;
	logic wr_msk2;
	logic wr_msk3;
	logic wr_msk4;
	assign wr_tag1 = sfr_wr_i && (sfr_addr_i == ADDR_TAG_BYTE_ONE);
	assign wr_tag2 = sfr_wr_i && (sfr_addr_i == ADDR_TAG_BYTE_TWO);
	assign wr_tag3 = sfr_wr_i && (sfr_addr_i == ADDR_TAG_BYTE_THREE);
	assign wr_tag4 = sfr_wr_i && (sfr_addr_i == ADDR_EXT_ID_TAG_LOW_BYTE);
	assign wr_msk1 = sfr_wr_i && (sfr_addr_i == ADDR_ID_MASK_BYTE_ONE);
	assign wr_msk2 = sfr_wr_i && (sfr_addr_i == ADDR_ID_MASK_BYTE_TWO);
	assign wr_msk3 = sfr_wr_i && (sfr_addr_i == ADDR_ID_MASK_BYTE_THREE);
	assign wr_msk4 = sfr_wr_i && (sfr_addr_i == ADDR_ID_MASK_BYTE_FOUR);

	always_ff @(posedge clk_i)
	begin
		if (wr_tag1)
			tag1 <= sfr_wdata_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (wr_tag2)
			tag2 <= sfr_wdata_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (wr_tag3)
			tag3 <= sfr_wdata_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (wr_tag4)
			tag4 <= sfr_wdata_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (wr_msk1)
			msk1 <= sfr_wdata_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (wr_msk2)
			msk2 <= sfr_wdata_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (wr_msk3)
			msk3 <= sfr_wdata_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (wr_msk4)
			msk4 <= sfr_wdata_i;
	end

	// Named fields of the fourth tag and mask bytes
	logic [4:0] identifier_tag_bits;
	logic remote_request_tag;
	logic reserved_one_tag;
	logic reserved_zero_tag;
	logic [4:0] identifier_mask_field;
	logic remote_request_mask;
	logic extension_flag_mask;
	assign identifier_tag_bits = tag4[7:POS_ID_LOW];
	assign remote_request_tag = tag4[POS_REMOTE];
	assign reserved_one_tag = tag4[POS_RES_ONE];
	assign reserved_zero_tag = tag4[POS_RES_ZERO];
	assign identifier_mask_field = msk4[7:POS_ID_LOW];
	assign remote_request_mask = msk4[POS_REMOTE];
	assign extension_flag_mask = msk4[POS_EXT_FLAG];

	// Hit marks mapped addresses only
	logic decoded;
	always_comb
	begin
		case (sfr_addr_i)
			ADDR_TAG_BYTE_ONE, ADDR_TAG_BYTE_TWO, ADDR_TAG_BYTE_THREE,
			ADDR_EXT_ID_TAG_LOW_BYTE, ADDR_ID_MASK_BYTE_ONE, ADDR_ID_MASK_BYTE_TWO,
			ADDR_ID_MASK_BYTE_THREE, ADDR_ID_MASK_BYTE_FOUR: decoded = 1'b1;
			default: decoded = 1'b0;
		endcase
	end

	// Reserved mask positions come back as a fixed pattern; callers must not rely on it
	logic [7:0] next_rdata;
	always_comb
	begin
		next_rdata = RESERVED_READ;
		case (sfr_addr_i)
			ADDR_TAG_BYTE_ONE: next_rdata = tag1;
			ADDR_TAG_BYTE_TWO: next_rdata = tag2;
			ADDR_TAG_BYTE_THREE: next_rdata = tag3;
			ADDR_EXT_ID_TAG_LOW_BYTE: next_rdata = tag4;
			ADDR_ID_MASK_BYTE_ONE: next_rdata = msk1;
			ADDR_ID_MASK_BYTE_TWO:
				next_rdata = ext_format_i ? msk2 : {msk2[7:5], RESERVED_READ[4:0]};
			ADDR_ID_MASK_BYTE_THREE:
				next_rdata = ext_format_i ? msk3 : RESERVED_READ;
			ADDR_ID_MASK_BYTE_FOUR:
				next_rdata = ext_format_i
					? {msk4[7:2], RESERVED_READ[1], msk4[0]}
					: {RESERVED_READ[7:3], msk4[2], RESERVED_READ[1], msk4[0]};
			default: next_rdata = RESERVED_READ;
		endcase
	end

	// Read data is zero whenever no read is under way
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sfr_rdata_o <= 8'h00;
			sfr_hit_o <= 1'b0;
		end
		else
		begin
			sfr_rdata_o <= sfr_rd_i ? next_rdata : 8'h00;
			sfr_hit_o <= (sfr_rd_i | sfr_wr_i) & decoded;
		end
	end

	// Field assembly for the comparator
	cafr_filt_if filt ();
	logic [28:0] mask_id;
	logic [28:0] tag_id;
	always_comb
	begin
		if (ext_format_i)
		begin
			mask_id = {msk1, msk2, msk3, identifier_mask_field};
			tag_id = {tag1, tag2, tag3, identifier_tag_bits};
		end
		else
		begin
			// Standard ids live in the low 11 bits; upper bits forced to match
			mask_id = {18'h00000, msk1, msk2[7:POS_STD_LOW]};
			tag_id = {18'h00000, tag1, tag2[7:POS_STD_LOW]};
		end
	end

	// Received candidate is held in flops so the compare sees a stable word
	// Own transmissions never reach the filter
	logic rx_take;
	assign rx_take = rx_check_i && !rx_transmit_i;
	logic [28:0] rx_id_q;
	logic rx_remote_q;
	logic rx_ext_q;
	always_ff @(posedge clk_i)
	begin
		if (rx_take)
			rx_id_q <= ext_format_i ? rx_id_i : {18'h00000, rx_id_i[10:0]};
	end

	always_ff @(posedge clk_i)
	begin
		if (rx_take)
			rx_remote_q <= rx_remote_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rx_take)
			rx_ext_q <= rx_ext_i;
	end

	assign filt.mask_id = mask_id;
	assign filt.tag_id = tag_id;
	assign filt.mask_remote = remote_request_mask;
	assign filt.tag_remote = remote_request_tag;
	assign filt.mask_ext = extension_flag_mask;
	assign filt.tag_ext = ext_format_i;
	assign filt.rx_id = rx_id_q;
	assign filt.rx_remote = rx_remote_q;
	assign filt.rx_ext = rx_ext_q;

	// Comparator is combinational on the held candidate
	cafr_compare #(
		.ID_W(EXT_ID_W)
	) u_cmp (
		.f(filt)
	);

	// Reserved bits 1/0 of the received frame are never stored; those of the tag byte are stored but never compared
	logic unused_res;
	assign unused_res = rx_res_one_i ^ rx_res_zero_i ^ reserved_one_tag ^ reserved_zero_tag;

	// Two busy cycles; checks arriving meanwhile are dropped
	cafr_state_e state;
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			state <= CAFR_IDLE;
		else
		begin
			case (state)
				CAFR_IDLE:
					if (rx_take)
						state <= CAFR_CMP;
				CAFR_CMP: state <= CAFR_DONE;
				CAFR_DONE: state <= CAFR_IDLE;
				default: state <= CAFR_IDLE;
			endcase
		end
	end

	// Decision pulse, one cycle per accepted check
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			rx_done_o <= 1'b0;
		else
			rx_done_o <= (state == CAFR_CMP);
	end

	// Accept holds its last decision until the next one
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			rx_accept_o <= 1'b0;
		else if (state == CAFR_CMP)
			rx_accept_o <= filt.hit;
	end
endmodule // cafr_regs
`default_nettype wire

/* verif/cafr_regs_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module cafr_regs_checker
	import cafr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic sfr_hit_o,
	input wire logic rx_check_i,
	input wire logic rx_transmit_i,
	input wire logic rx_done_o,
	input wire logic rx_accept_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence idle_chk;
		rx_check_i && !$past(rx_check_i) && !$past(rx_check_i, 2);
	endsequence
	sequence wr_at(logic [7:0] a);
		sfr_wr_i && sfr_addr_i == a;
	endsequence
	sequence rd_at(logic [7:0] a);
		sfr_rd_i && !sfr_wr_i && sfr_addr_i == a;
	endsequence
	// Only defined bit positions are compared
	property rb(logic [7:0] a, logic [7:0] m);
		wr_at(a) ##1 rd_at(a) |=> ((sfr_rdata_o ^ $past(sfr_wdata_i, 2)) & m) == 8'h00;
	endproperty
	rb_mask_one_a: assert property (rb(ADDR_ID_MASK_BYTE_ONE, 8'hff))
		else $error("mask byte one read-back differs");
	rb_mask_four_a: assert property (rb(ADDR_ID_MASK_BYTE_FOUR, 8'h05))
		else $error("mask byte four flags read-back differs");
	rb_tag_four_a: assert property (rb(ADDR_EXT_ID_TAG_LOW_BYTE, 8'h05))
		else $error("tag byte four flags read-back differs");
	map_hit_a: assert property ((sfr_wr_i || sfr_rd_i) && sfr_addr_i == ADDR_ID_MASK_BYTE_FOUR |=> sfr_hit_o)
		else $error("mapped access gave no hit");
	tx_ignore_a: assert property (idle_chk and rx_transmit_i |-> ##2 !rx_done_o)
		else $error("transmit frame was filtered");
	done_lat_a: assert property (idle_chk and !rx_transmit_i |-> ##2 rx_done_o)
		else $error("decision not ready two cycles after check");
	done_pulse_a: assert property (rx_done_o |=> !rx_done_o)
		else $error("decision pulse too long");
	done_cause_a: assert property (rx_done_o |-> $past(rx_check_i, 2) && !$past(rx_transmit_i, 2))
		else $error("decision without a reception check");
	accept_hold_a: assert property (!rx_done_o |-> $stable(rx_accept_o))
		else $error("accept changed without a decision");
endmodule // cafr_regs_checker
bind cafr_regs cafr_regs_checker i_cafr_regs_checker (.clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i,
	.sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .rx_check_i, .rx_transmit_i,
	.rx_done_o, .rx_accept_o);
`default_nettype wire

/* verif/cafr_node.sv */
`timescale 1ns/10ps
`default_nettype none
module cafr_node
(
	input wire logic clk_i,
	output logic rx_check_o,
	output logic rx_transmit_o,
	output logic [28:0] rx_id_o,
	output logic rx_remote_o,
	output logic rx_ext_o,
	output logic [1:0] rx_res_o
);
	initial {rx_check_o, rx_transmit_o, rx_id_o, rx_remote_o, rx_ext_o, rx_res_o} = '0;
	// Frame fields are only valid with the check pulse; four cycles apart
	task automatic send(input logic [28:0] id, input logic rm, input logic ex, input logic tx);
		@(negedge clk_i);
		{rx_check_o, rx_transmit_o, rx_remote_o, rx_ext_o, rx_id_o, rx_res_o} = {1'b1, tx, rm, ex, id, id[1:0]};
		@(negedge clk_i);
		rx_check_o = 1'b0;
		{rx_remote_o, rx_ext_o, rx_id_o} = ~{rx_remote_o, rx_ext_o, rx_id_o};
		repeat (2) @(negedge clk_i);
	endtask
endmodule // cafr_node
`default_nettype wire

/* verif/can_acceptance_filter_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module can_acceptance_filter_regs_tb import cafr_pkg::*;;
	logic clk_i = 1'b0;
	logic rst_n_i, wr, rd, fmt, chk, tx, rm, ex, done, acc, hit, rmt, exx, txx, ea;
	logic rd_d = 1'b0;
	logic [7:0] addr, wd, rdat, a;
	logic [28:0] rid, id, tg, mk;
	logic [1:0] res;
	logic [7:0] r [16];
	logic [16:0] rq [$];
	logic aq [$];
	int num_errors = 0;
	int total_checks = 0;
	logic [31:0] sd = 32'hdfd16ff0;
	cafr_regs i_cafr_regs (.clk_i, .rst_n_i, .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
		.sfr_wdata_i(wd), .sfr_rdata_o(rdat), .sfr_hit_o(hit), .ext_format_i(fmt),
		.rx_check_i(chk), .rx_transmit_i(tx), .rx_id_i(rid), .rx_remote_i(rm), .rx_ext_i(ex),
		.rx_res_one_i(res[1]), .rx_res_zero_i(res[0]), .rx_done_o(done), .rx_accept_o(acc));
	cafr_node i_cafr_node (.clk_i, .rx_check_o(chk), .rx_transmit_o(tx), .rx_id_o(rid),
		.rx_remote_o(rm), .rx_ext_o(ex), .rx_res_o(res));
	initial forever #12.5 clk_i = ~clk_i;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] cm(input logic [3:0] i, input logic f);
		case (i)
			4'hd, 4'h5: return f ? 8'hff : 8'he0;
			4'he, 4'h6: return f ? 8'hff : 8'h00;
			4'hf: return f ? 8'hff : 8'h05;
			4'h7: return f ? 8'hfd : 8'h05;
			default: return 8'hff;
		endcase
	endfunction
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		$display("errors=%0d checks=%0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Caller stands at a falling edge; strobes persist until the next call
	task automatic bus(input logic [1:0] op, input logic [7:0] ad, input logic [7:0] d);
		{wr, rd, addr, wd} = {op, ad, d};
		if (op == 2'b01)
			rq.push_back(ad == 8'hc0 ? {1'b0, 8'hff, 8'h00} : {1'b1, cm(ad[3:0], fmt), r[ad[3:0]]});
		@(negedge clk_i);
	endtask
	task automatic chk_rd();
		logic [16:0] e;
		e = rq.pop_front();
		cmp({7'h0, hit, rdat & e[15:8]}, {7'h0, e[16], e[7:0] & e[15:8]});
	endtask
	task automatic chk_acc();
		cmp({14'h0, done, acc}, aq.size() != 0 ? {14'h0, 1'b1, aq.pop_front()} : 16'h0);
	endtask
	always @(posedge clk_i)
	begin
		if (rd_d)
			chk_rd();
		if (done !== 1'b0)
			chk_acc();
		rd_d <= rd;
	end
	initial
	begin
		{rst_n_i, wr, rd, fmt, addr, wd} = '0;
		repeat (8) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		for (int f = 1; f >= 0; f--)
		begin
			fmt = f[0];
			for (int i = 0; i < 9; i++)
			begin
				a = i == 8 ? 8'hc0 : (i < 4 ? 8'hbc + 8'(i) : 8'hc0 + 8'(i));
				sd = lfsr(sd);
				r[a[3:0]] = sd[7:0] & cm(a[3:0], fmt);
				bus(2'b10, a, r[a[3:0]]);
				bus(2'b01, a, 8'h00);
			end
			bus(2'b00, 8'h00, 8'h00);
			tg = fmt ? {r[12], r[13], r[14], r[15][7:3]} : {18'h0, r[12], r[13][7:5]};
			mk = fmt ? {r[4], r[5], r[6], r[7][7:3]} : {18'h0, r[4], r[5][7:5]};
			for (int k = 0; k < 16; k++)
			begin
				sd = lfsr(sd);
				id = tg ^ (k[0] ? sd[28:0] & sd[31:3] & sd[30:2] : 29'h0);
				rmt = r[15][2] ^ (sd[0] & sd[1]);
				exx = fmt ^ (sd[2] & sd[3]);
				txx = k == 5;
				ea = ((id ^ tg) & mk) == 29'h0 && !((rmt ^ r[15][2]) & r[7][2]) && !((exx ^ fmt) & r[7][0]);
				if (!txx)
					aq.push_back(ea);
				i_cafr_node.send(id, rmt, exx, txx);
			end
		end
		repeat (4) @(negedge clk_i);
		cmp(16'(aq.size()), 16'h0);
		cmp(16'(rq.size()), 16'h0);
		stop_test();
	end
	initial
	begin
		#100000;
		num_errors++;
		stop_test();
	end
endmodule // can_acceptance_filter_regs_tb
`default_nettype wire
